// ---- cgs_pkg.sv ----
/*
 * Package for the CAN global status and error flag block: register
 * offsets, field positions, reset values and the event and state carrier structs.
 * Assumes an 8-bit SFR port with byte addresses.
 */
`default_nettype none
package cgs_pkg;
	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] CGS_ADDR_FLAGS  = 8'h9b;
	localparam logic [7:0] CGS_ADDR_TEC    = 8'h9c;
	localparam logic [7:0] CGS_ADDR_REC    = 8'h9d;
	localparam logic [7:0] CGS_ADDR_IE     = 8'hc1;
	localparam logic [7:0] CGS_ADDR_STATUS = 8'haa;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CGS_ST_OVL  = 6;
	localparam int CGS_ST_TX   = 4;
	localparam int CGS_ST_RX   = 3;
	localparam int CGS_ST_EN   = 2;
	localparam int CGS_ST_BUS_OFF_STATE = 1;
	localparam int CGS_ST_ERROR_PASSIVE_STATE = 0;
	localparam int CGS_FL_ANY  = 7;
	localparam int CGS_FL_TIM  = 5;
	localparam int CGS_FL_BUF  = 4;
	localparam int CGS_FL_STF  = 3;
	localparam int CGS_FL_CRC  = 2;
	localparam int CGS_FL_FRM  = 1;
	localparam int CGS_FL_ACK  = 0;
	localparam int CGS_IE_RX   = 5;
	localparam int CGS_IE_TX   = 4;
	localparam int CGS_IE_OBJ  = 3;
	localparam int CGS_IE_BUF  = 2;
	localparam int CGS_IE_GEN  = 1;
	// ----------------------------------------------------------------
	// Reset values, masks and limits
	// ----------------------------------------------------------------
	localparam logic [7:0] CGS_RST_FLAGS = 8'h00;
	localparam logic [7:0] CGS_RST_IE    = 8'h00;
	localparam logic [7:0] CGS_RST_CNT   = 8'h00;
	localparam logic [7:0] CGS_IE_MASK   = 8'h3e;
	localparam logic [7:0] CGS_FL_WMASK  = 8'h3f;
	localparam int         CGS_STUFF_MAX = 5;
	localparam logic [15:0] CGS_TIMER_MAX = 16'hffff;

	// Events from the protocol engine, one cycle each unless noted
	typedef struct packed {
		logic bit_valid;   // One received, sampled bit
		logic bit_value;
		logic stuff_check; // Stuff rule applies to this bit
		logic crc_end;     // Received CRC field complete
		logic form_bad;    // Illegal bit in a fixed-form field
		logic ack_slot;    // Ack slot of own transmitted frame
		logic buf_full;    // Reception buffer became full
	} cgs_event_t;

	typedef struct packed {
		logic tx_frame;    // Level: transmitter driving a frame or ack
		logic tx_pending;  // Level: frame queued
		logic ifs;         // Level: interframe spacing
		logic rx_frame;    // Level: receiver monitoring a frame
		logic ovl_frame;   // Level: own overload frame on the bus
		logic enabled;     // Level: controller really running
		logic bus_off;
		logic err_passive;
	} cgs_state_t;
endpackage : cgs_pkg
`default_nettype wire

// ---- cgs_top.sv ----
/*
 * CAN global status, error flags, error counters and interrupt image.
 * Assumes the protocol engine on the same clock supplies the events and
 * state levels, the CRC computed over SOF..data, and the error counts.
 */
`timescale 1ns/1ns
`default_nettype none
module cgs_top
	import cgs_pkg::*;
#(
	parameter int CRC_W = 15
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic [7:0]       sfr_addr,
	input  wire logic             sfr_wr,
	input  wire logic [7:0]       sfr_wdata,
	output logic      [7:0]       sfr_rdata,
	input  wire cgs_event_t       ev,
	input  wire cgs_state_t       st,
	input  wire logic [CRC_W-1:0] crc_calc,
	input  wire logic [CRC_W-1:0] crc_rx,
	input  wire logic [15:0]      can_timer,
	input  wire logic             timer_ie,
	input  wire logic             obj_irq,
	input  wire logic [7:0]       tec_in,
	input  wire logic [7:0]       rec_in,
	output logic                  can_irq
);
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0]  flags_reg, flags_next;
	logic [7:0]  ie_reg, ie_next;
	logic [7:0]  tec_reg, rec_reg;
	logic [7:0]  status_reg, status_next;
	logic [15:0] timer_prev_reg;
	logic [2:0]  run_reg, run_next;
	logic        last_bit_reg;

	// ----------------------------------------------------------------
	// Event detection
	// ----------------------------------------------------------------
	wire timer_wrap = (timer_prev_reg == CGS_TIMER_MAX) &&
		(can_timer == 16'h0000);
	wire same_bit   = ev.bit_valid && (ev.bit_value == last_bit_reg);
	wire stuff_err  = same_bit && ev.stuff_check &&
		(run_reg == 3'(CGS_STUFF_MAX));
	wire crc_err    = ev.crc_end && (crc_calc != crc_rx);
	wire ack_err    = ev.ack_slot && ev.bit_value;

	always_comb begin
		run_next = run_reg;
		if (ev.bit_valid) begin
			// Saturates; a stuff error is flagged once per run
			if (!same_bit)
				run_next = 3'h1;
			else if (run_reg != 3'h6)
				run_next = run_reg + 3'h1;
		end
	end

	wire [7:0] set_vec = {2'b00, timer_wrap, ev.buf_full, stuff_err,
		crc_err, ev.form_bad, ack_err};

	// ----------------------------------------------------------------
	// Register writes; set wins over a same-cycle clear
	// ----------------------------------------------------------------
	// One decoder shared by the write strobes
	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		return a == r;
	endfunction : hit

	wire wr_flags = sfr_wr && hit(sfr_addr, CGS_ADDR_FLAGS);
	wire wr_ie    = sfr_wr && hit(sfr_addr, CGS_ADDR_IE);
	wire [7:0] keep_mask = wr_flags ?
		(sfr_wdata | ~CGS_FL_WMASK) : 8'hff;

	// Error interrupt from latched flags, status never feeds it
	wire irq_gen  = ie_reg[CGS_IE_GEN] && |flags_reg[CGS_FL_STF:CGS_FL_ACK];
	wire irq_buf  = ie_reg[CGS_IE_BUF] && flags_reg[CGS_FL_BUF];
	wire irq_tim  = timer_ie && flags_reg[CGS_FL_TIM];
	wire irq_any  = irq_gen || irq_buf || irq_tim || obj_irq;

	always_comb begin
		flags_next = ((flags_reg & keep_mask) | set_vec) & CGS_FL_WMASK;
		flags_next[CGS_FL_ANY] = irq_any;
		ie_next = wr_ie ? (sfr_wdata & CGS_IE_MASK) : ie_reg;
	end

	// Status is built from engine levels only; writes never reach it
	always_comb begin
		status_next = 8'h00;
		status_next[CGS_ST_OVL]  = st.ovl_frame;
		status_next[CGS_ST_TX]   = st.tx_frame ||
			(st.ifs && st.tx_pending);
		status_next[CGS_ST_RX]   = st.rx_frame;
		status_next[CGS_ST_EN]   = st.enabled;
		status_next[CGS_ST_BUS_OFF_STATE] = st.bus_off;
		status_next[CGS_ST_ERROR_PASSIVE_STATE] = st.err_passive;
	end

	// Flags and enables: the software-writable state
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			flags_reg <= CGS_RST_FLAGS;
			ie_reg    <= CGS_RST_IE;
		end else begin
			flags_reg <= flags_next;
			ie_reg    <= ie_next;
		end
	end

	// Counters are copies only; no write path reaches them
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tec_reg <= CGS_RST_CNT;
			rec_reg <= CGS_RST_CNT;
		end else begin
			tec_reg <= tec_in;
			rec_reg <= rec_in;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			status_reg <= 8'h00;
		else
			status_reg <= status_next;
	end

	// Idle bus is recessive, so the run starts from a one
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			timer_prev_reg <= 16'h0000;
			run_reg        <= 3'h0;
			last_bit_reg   <= 1'b1;
		end else begin
			timer_prev_reg <= can_timer;
			run_reg        <= run_next;
			if (ev.bit_valid)
				last_bit_reg <= ev.bit_value;
		end
	end

	// ----------------------------------------------------------------
	// Read mux; counters only readable
	// ----------------------------------------------------------------
	always_comb begin
		case (sfr_addr)
			CGS_ADDR_FLAGS:  sfr_rdata = flags_reg;
			CGS_ADDR_TEC:    sfr_rdata = tec_reg;
			CGS_ADDR_REC:    sfr_rdata = rec_reg;
			CGS_ADDR_IE:     sfr_rdata = ie_reg;
			CGS_ADDR_STATUS: sfr_rdata = status_reg;
			default:         sfr_rdata = 8'h00;
		endcase
	end

	assign can_irq = flags_reg[CGS_FL_ANY];

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_ovl_status: assert property (
		st.ovl_frame |=> status_reg[CGS_ST_OVL])
		else $error("overload bit not high");

	a_ovl_idle: assert property (
		!st.ovl_frame |=> !status_reg[CGS_ST_OVL])
		else $error("overload bit high when idle");

	a_tx_busy: assert property (
		st.tx_frame |=> status_reg[CGS_ST_TX])
		else $error("tx busy missing");

	a_tx_idle: assert property (
		(!st.tx_frame && !(st.ifs && st.tx_pending))
		|=> !status_reg[CGS_ST_TX])
		else $error("tx busy while idle");

	a_tx_queued: assert property (
		(st.ifs && st.tx_pending) |=> status_reg[CGS_ST_TX])
		else $error("tx busy missing in spacing");

	a_rx_busy: assert property (
		st.rx_frame |=> status_reg[CGS_ST_RX])
		else $error("rx busy missing");

	a_rx_idle: assert property (
		!st.rx_frame |=> !status_reg[CGS_ST_RX])
		else $error("rx busy while idle");

	a_irq_source: assert property (
		!(irq_tim || irq_buf || irq_gen || obj_irq) |=> !can_irq)
		else $error("irq without a source");

	a_en_true: assert property (
		1'b1 |=> status_reg[CGS_ST_EN] == $past(st.enabled))
		else $error("enable bit not actual state");

	a_status_ro: assert property (
		(sfr_wr && sfr_addr == CGS_ADDR_STATUS && !$changed(st))
		|=> $stable(status_reg))
		else $error("status changed by write");

	a_status_rsvd: assert property (
		status_reg[7] == 1'b0 && status_reg[5] == 1'b0)
		else $error("reserved status bit set");

	a_irq_image: assert property (
		(irq_tim || irq_buf || irq_gen) |=> can_irq ##0
		(sfr_addr != CGS_ADDR_FLAGS || sfr_rdata[7]))
		else $error("irq image missing");

	a_flags_rsvd: assert property (
		flags_reg[6] == 1'b0)
		else $error("reserved flag bit set");

	a_timer_wrap: assert property (
		timer_wrap |=> flags_reg[CGS_FL_TIM])
		else $error("timer wrap lost");

	a_tim_gate: assert property (
		(!timer_ie && !irq_buf && !irq_gen && !obj_irq) |=> !can_irq)
		else $error("timer irq while disabled");

	a_buf_set: assert property (
		ev.buf_full |=> flags_reg[CGS_FL_BUF])
		else $error("buffer flag not set");

	a_buf_sticky: assert property (
		(flags_reg[CGS_FL_BUF] && !wr_flags) |=> flags_reg[CGS_FL_BUF])
		else $error("buffer flag dropped");

	a_stuff_set: assert property (
		stuff_err |=> flags_reg[CGS_FL_STF])
		else $error("stuff flag not set");

	a_crc_set: assert property (
		crc_err |=> flags_reg[CGS_FL_CRC])
		else $error("crc flag not set");

	a_form_set: assert property (
		ev.form_bad |=> flags_reg[CGS_FL_FRM])
		else $error("form flag not set");

	a_ack_set: assert property (
		ack_err |=> flags_reg[CGS_FL_ACK])
		else $error("ack flag not set");

	a_err_sticky: assert property (
		!wr_flags |=> (flags_reg[CGS_FL_STF:CGS_FL_ACK] &
		$past(flags_reg[CGS_FL_STF:CGS_FL_ACK])) ==
		$past(flags_reg[CGS_FL_STF:CGS_FL_ACK]))
		else $error("error flag dropped");

	a_tec_copy: assert property (
		1'b1 |=> tec_reg == $past(tec_in))
		else $error("tx error count wrong");

	a_rec_copy: assert property (
		1'b1 |=> rec_reg == $past(rec_in))
		else $error("rx error count wrong");

	a_ie_reserved: assert property (
		ie_reg[7] == 1'b0 && ie_reg[6] == 1'b0 && ie_reg[0] == 1'b0)
		else $error("reserved enable bit set");

	a_ie_write: assert property (
		wr_ie |=> ie_reg == ($past(sfr_wdata) & CGS_IE_MASK))
		else $error("enable write lost");

	a_write_one: assert property (
		(wr_flags && sfr_wdata[CGS_FL_FRM] && flags_reg[CGS_FL_FRM])
		|=> flags_reg[CGS_FL_FRM])
		else $error("write one cleared flag");

	a_write_zero: assert property (
		(wr_flags && !sfr_wdata[CGS_FL_FRM] && !ev.form_bad)
		|=> !flags_reg[CGS_FL_FRM])
		else $error("write zero kept flag");

	a_set_wins: assert property (
		(wr_flags && !sfr_wdata[CGS_FL_ACK] && ack_err)
		|=> flags_reg[CGS_FL_ACK])
		else $error("clear beat a new error");

	c_stuff: cover property (stuff_err ##1 flags_reg[CGS_FL_STF]);
	c_irq:   cover property (!can_irq ##1 can_irq);
	c_clear: cover property (flags_reg[CGS_FL_FRM] ##1 !flags_reg[CGS_FL_FRM]);
	c_queue: cover property (st.ifs && st.tx_pending && !st.tx_frame);
	c_wrap:  cover property (timer_wrap ##1 flags_reg[CGS_FL_TIM]);
endmodule : cgs_top
`default_nettype wire

// ---- cgs_node.sv ----
/*
 * Far-side node model: turns bench calls into engine events.
 * Assumes one clock shared with the block under test.
 */
`timescale 1ns/1ns
`default_nettype none
module cgs_node
	import cgs_pkg::*;
(
	input  wire logic        clk,
	output cgs_event_t       ev,
	output logic      [14:0] crc_calc,
	output logic      [14:0] crc_rx
);
	// ----------------------------------------------------------------
	// Event tasks
	// ----------------------------------------------------------------
	initial begin
		ev = '0;
		crc_calc = 15'h0000;
		crc_rx = 15'h0000;
	end
	// One cycle only, so a held line cannot set a flag twice
	task automatic pulse(input cgs_event_t e);
		@(posedge clk);
		#1 ev = e;
		@(posedge clk);
		#1 ev = '0;
	endtask : pulse
	task automatic run(input int n, input logic v);
		repeat (n) pulse('{bit_valid: 1'b1, bit_value: v,
			stuff_check: 1'b1, default: 1'b0});
	endtask : run
	task automatic crc(input logic [14:0] c, input logic [14:0] r);
		crc_calc = c;
		crc_rx = r;
		pulse('{crc_end: 1'b1, default: 1'b0});
	endtask : crc
endmodule : cgs_node
`default_nettype wire

// ---- tb_can_global_status_and_error_flags.sv ----
/*
 * Self-checking bench for the global status and error flag block.
 * Assumes the package constants and the far-side node model.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_can_global_status_and_error_flags
	import cgs_pkg::*;
;
	logic             clk = 1'b0;
	logic             reset_n = 1'b0;
	logic       [7:0] sfr_addr = 8'h00;
	logic             sfr_wr = 1'b0;
	logic       [7:0] sfr_wdata = 8'h00;
	logic       [7:0] sfr_rdata;
	cgs_event_t       ev;
	cgs_state_t       st = '0;
	logic      [14:0] crc_calc;
	logic      [14:0] crc_rx;
	logic      [15:0] can_timer = 16'h0000;
	logic             timer_ie = 1'b0;
	logic             obj_irq = 1'b0;
	logic       [7:0] tec_in = 8'h5a;
	logic       [7:0] rec_in = 8'ha5;
	logic             can_irq;
	int               errors = 0;
	int               num_checks = 0;
	logic      [15:0] st_tab [8] = '{16'h0840, 16'h8010, 16'h6010,
		16'h1008, 16'h0404, 16'h0202, 16'h0101, 16'hff5f};
	// ----------------------------------------------------------------
	// Instances and tasks
	// ----------------------------------------------------------------
	cgs_top #(.CRC_W(15)) cgs_top_inst (.clk(clk), .reset_n(reset_n),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .ev(ev), .st(st), .crc_calc(crc_calc),
		.crc_rx(crc_rx), .can_timer(can_timer), .timer_ie(timer_ie),
		.obj_irq(obj_irq), .tec_in(tec_in), .rec_in(rec_in),
		.can_irq(can_irq));
	cgs_node cgs_node_inst (.clk(clk), .ev(ev), .crc_calc(crc_calc),
		.crc_rx(crc_rx));
	always #50 clk = ~clk;
	task automatic chk(input string n, input logic [7:0] e,
		input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(posedge clk);
		#1 sfr_wr = 1'b0;
	endtask : wr
	// Flag reads also check the pin, which must match the image bit
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		#1 sfr_addr = a;
		#10 chk($sformatf("reg %h", a), e, sfr_rdata);
		if (a == CGS_ADDR_FLAGS)
			chk("can_irq", {7'h00, e[7]}, {7'h00, can_irq});
	endtask : rd
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : finish_test
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		#400000;
		errors++;
		finish_test();
	end
	initial begin
		rd(CGS_ADDR_TEC, 8'h00);
		rd(CGS_ADDR_REC, 8'h00);
		repeat (3) @(posedge clk);
		#1 reset_n = 1'b1;
		wr(CGS_ADDR_TEC, 8'h00);
		rd(CGS_ADDR_TEC, 8'h5a);
		wr(CGS_ADDR_REC, 8'h00);
		rd(CGS_ADDR_REC, 8'ha5);
		wr(CGS_ADDR_IE, 8'hff);
		rd(CGS_ADDR_IE, 8'h3e);
		wr(8'h9a, 8'hff);
		rd(8'h9a, 8'h00);
		$display("test registers done");
		foreach (st_tab[i]) begin
			@(posedge clk);
			#1 st = cgs_state_t'(st_tab[i][15:8]);
			wr(CGS_ADDR_STATUS, 8'h00);
			rd(CGS_ADDR_STATUS, st_tab[i][7:0]);
			rd(CGS_ADDR_FLAGS, 8'h00);
		end
		st = '0;
		$display("test status done");
		wr(CGS_ADDR_IE, 8'h00);
		can_timer = 16'hfffe;
		@(posedge clk);
		#1 can_timer = 16'hffff;
		@(posedge clk);
		#1 can_timer = 16'h0000;
		repeat (2) @(posedge clk);
		rd(CGS_ADDR_FLAGS, 8'h20);
		timer_ie = 1'b1;
		rd(CGS_ADDR_FLAGS, 8'ha0);
		wr(CGS_ADDR_FLAGS, 8'hff);
		rd(CGS_ADDR_FLAGS, 8'ha0);
		wr(CGS_ADDR_FLAGS, 8'hdf);
		rd(CGS_ADDR_FLAGS, 8'h00);
		timer_ie = 1'b0;
		$display("test timer done");
		cgs_node_inst.run(5, 1'b0);
		cgs_node_inst.run(5, 1'b1);
		rd(CGS_ADDR_FLAGS, 8'h00);
		cgs_node_inst.run(6, 1'b0);
		rd(CGS_ADDR_FLAGS, 8'h08);
		cgs_node_inst.crc(15'h1234, 15'h1234);
		cgs_node_inst.pulse('{ack_slot: 1'b1, default: 1'b0});
		rd(CGS_ADDR_FLAGS, 8'h08);
		cgs_node_inst.crc(15'h1234, 15'h1235);
		rd(CGS_ADDR_FLAGS, 8'h0c);
		cgs_node_inst.pulse('{form_bad: 1'b1, default: 1'b0});
		rd(CGS_ADDR_FLAGS, 8'h0e);
		cgs_node_inst.pulse('{ack_slot: 1'b1, bit_value: 1'b1,
			default: 1'b0});
		rd(CGS_ADDR_FLAGS, 8'h0f);
		cgs_node_inst.pulse('{buf_full: 1'b1, default: 1'b0});
		rd(CGS_ADDR_FLAGS, 8'h1f);
		wr(CGS_ADDR_IE, 8'h02);
		rd(CGS_ADDR_FLAGS, 8'h9f);
		wr(CGS_ADDR_FLAGS, 8'h10);
		rd(CGS_ADDR_FLAGS, 8'h10);
		wr(CGS_ADDR_IE, 8'h04);
		rd(CGS_ADDR_FLAGS, 8'h90);
		wr(CGS_ADDR_FLAGS, 8'h00);
		rd(CGS_ADDR_FLAGS, 8'h00);
		obj_irq = 1'b1;
		rd(CGS_ADDR_FLAGS, 8'h80);
		obj_irq = 1'b0;
		$display("test error flags done");
		finish_test();
	end
endmodule : tb_can_global_status_and_error_flags
`default_nettype wire
